/* oep_regs.svh */
// Register offsets, field positions and fixed values of the OAM endpoint.
// Assumes inclusion by bare name from the design files.
`ifndef OEP_REGS_SVH
`define OEP_REGS_SVH
// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define OEP_A_CTRL 8'h00
`define OEP_A_IRQ_ENA 8'h04
`define OEP_A_STICKY 8'h08
`define OEP_A_CCM_STAT 8'h0C
`define OEP_A_TX_TRANS 8'h10
`define OEP_A_RX_TRANS 8'h14
`define OEP_A_RX_CNT 8'h18
`define OEP_A_MISM_CNT 8'h1C
`define OEP_A_TXREP_CNT 8'h20
`define OEP_A_CRC_CNT 8'h24
`define OEP_A_OAM_CNT 8'h28
`define OEP_A_DATA_CNT 8'h2C
`define OEP_A_EXTRACT 8'h30
// --------------------------------------------------------------
// Control bits
// --------------------------------------------------------------
`define OEP_C_TSTHW 0
`define OEP_C_LBMHW 1
`define OEP_C_LBRHW 2
`define OEP_C_TSTSEQ 3
`define OEP_C_LBMSEQ 4
`define OEP_C_AUTOREP 5
`define OEP_C_TSTCRC 6
`define OEP_C_LBRCRC 7
`define OEP_C_MPLSTP 8
`define OEP_C_CPY_TST 9
`define OEP_C_CPY_LBM 10
`define OEP_C_CPY_LBR 11
`define OEP_C_CPY_END 12
`define OEP_C_CNT_TST 13
`define OEP_C_CNT_LBM 14
`define OEP_C_CNT_LBR 15
`define OEP_C_DAT_TST 16
`define OEP_C_DAT_LBM 17
`define OEP_C_DAT_LBR 18
`define OEP_C_LSEL 19
`define OEP_C_MSEL 22
`define OEP_SEL_W 3
// --------------------------------------------------------------
// Sticky / enable bits and status layout
// --------------------------------------------------------------
`define OEP_S_PORT 0
`define OEP_S_IF 1
`define OEP_S_LOSS 2
`define OEP_S_END 3
`define OEP_S_TSTRX 4
`define OEP_S_LBMRX 5
`define OEP_S_LBRRX 6
`define OEP_S_MISM 7
`define OEP_ST_DEFECT 3
`define OEP_ST_LMNEXT 4
`define OEP_ST_PORT 8
`define OEP_ST_IF 16
// --------------------------------------------------------------
// Fixed values
// --------------------------------------------------------------
`define OEP_TLV_PORT 8'h02
`define OEP_TLV_IF 8'h04
`define OEP_PAT1 8'h01
`define OEP_PAT3 8'h03
`define OEP_MISS_MAX 3'h7
`define OEP_CRC_INIT 32'hFFFFFFFF
`define OEP_CRC_POLY 32'hEDB88320
`define OEP_ONE 32'h00000001
`define OEP_HALF 16
`endif

/* oep_pkg.sv */
// Types shared by the OAM endpoint and its environment.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package oep_pkg;
  // PDU kinds seen on the frame pipeline
  typedef enum logic [2:0] {
    OEP_CCM, OEP_TST, OEP_LBM, OEP_LBR, OEP_OTHER
  } oep_pdu_e;
  // Parsed received frame, valid in one cycle
  typedef struct packed {
    oep_pdu_e kind;
    logic [31:0] trans_id;
    logic [7:0] tlv0_type;
    logic [7:0] tlv1_type;
    logic [7:0] port_state;
    logic [7:0] if_state;
    logic [7:0] pattern;
    logic test_first;
    logic [31:0] crc;
  } oep_rx_s;
  // Transmitted frame, in and out of the lookup
  typedef struct packed {
    oep_pdu_e kind;
    logic [31:0] seq;
    logic lm_insert;
  } oep_tx_s;
endpackage
`default_nettype wire

/* oep_endpoint.sv */
// OAM endpoint: CCM status/continuity, LM insertion, TST and loopback.
// Assumes a same-clock frame pipeline and a single-cycle register port.
//
// Operation
// - Status TLVs accepted only directly after PDU.
// - Foreign first TLV stops parsing, flags, copies.
// - Status TLV change sets flag and interrupt.
// - Miss counter counts timer expiries, cleared by CCM.
// - Miss count seven sets continuity loss defect.
// - Defect change sets loss flag, gated interrupt.
// - Valid CCM clears defect and sets flag.
// - Insert-next flag adds LM, then clears.
// - Software or insertion timer sets insert-next.
// - Hardware disabled: statistics only, frame untouched.
// - Enables gate frame and data counters.
// - TST/LBM sequence written, stored value incremented.
// - Rx transaction checked against stored plus one.
// - Mismatched LBR still counted valid.
// - One-shot or copy-all extraction to CPU.
// - Valid LBM triggers injected loop reply.
// - Count every valid transmitted LBR.
// - Optional CRC check of first TEST TLV.
// - CRC checked only for patterns one, three.
// - No reply CRC check in MPLS-TP mode.
//
// Added by the designer: the placing of the registers and strobed register access.
`include "oep_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module oep_endpoint import oep_pkg::*; #(
  parameter int CNT_W = 32,
  parameter int NTMR = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NTMR-1:0] tmr_expire,
  input wire logic rx_byte_vld,
  input wire logic [7:0] rx_byte,
  input wire logic rx_vld,
  input wire oep_rx_s rx_frm,
  input wire logic tx_vld,
  input wire oep_tx_s tx_frm,
  output logic tx_out_vld,
  output oep_tx_s tx_out,
  output logic lbr_inject,
  output logic cpu_copy,
  output logic irq
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Reflected CRC-32, one byte per call
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `OEP_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  function automatic logic is_status(input logic [7:0] t);
    return (t == `OEP_TLV_PORT) || (t == `OEP_TLV_IF);
  endfunction
  logic [31:0] ctrl_q, sticky_q, sticky_set, crc_q;
  logic [2:0] irq_ena_q, miss_q;
  logic defect_q, lmnext_q, extract_q;
  logic [7:0] port_q, if_q;
  logic [31:0] tx_trans_q, rx_trans_q;
  logic [CNT_W-1:0] rx_cnt_q, mism_cnt_q, txrep_cnt_q, crc_cnt_q;
  logic [15:0] oam_tx_q, oam_rx_q, dat_tx_q, dat_rx_q;
  logic wr_ctrl, wr_sticky, wr_stat, wr_extr;
  logic rx_ccm, rx_tst, rx_lbm, rx_lbr, rx_seq, seq_hw, mism;
  logic loss_tick, lm_tick, port_ok, if_ok, end_tlv;
  logic tx_tst, tx_lbm, tx_lbr, tx_ccm, seq_upd, crc_chk;
  logic cnt_rx, cnt_tx, dat_rx, dat_tx;
  assign wr_ctrl = reg_wr && (reg_addr == `OEP_A_CTRL);
  assign wr_sticky = reg_wr && (reg_addr == `OEP_A_STICKY);
  assign wr_stat = reg_wr && (reg_addr == `OEP_A_CCM_STAT);
  assign wr_extr = reg_wr && (reg_addr == `OEP_A_EXTRACT);
  // ------------------------------------------------------------
  // Frame classification
  // ------------------------------------------------------------
  assign rx_ccm = rx_vld && (rx_frm.kind == OEP_CCM);
  assign rx_tst = rx_vld && (rx_frm.kind == OEP_TST);
  assign rx_lbm = rx_vld && (rx_frm.kind == OEP_LBM);
  assign rx_lbr = rx_vld && (rx_frm.kind == OEP_LBR);
  assign rx_seq = rx_tst || rx_lbr;
  assign tx_ccm = tx_vld && (tx_frm.kind == OEP_CCM);
  assign tx_tst = tx_vld && (tx_frm.kind == OEP_TST);
  assign tx_lbm = tx_vld && (tx_frm.kind == OEP_LBM);
  assign tx_lbr = tx_vld && (tx_frm.kind == OEP_LBR);
  assign loss_tick = tmr_expire[ctrl_q[`OEP_C_LSEL +: `OEP_SEL_W]];
  assign lm_tick = tmr_expire[ctrl_q[`OEP_C_MSEL +: `OEP_SEL_W]];
  // Status TLVs count only in the first two slots after the PDU
  assign port_ok = (rx_frm.tlv0_type == `OEP_TLV_PORT) ||
    (is_status(rx_frm.tlv0_type) &&
     rx_frm.tlv1_type == `OEP_TLV_PORT);
  assign if_ok = (rx_frm.tlv0_type == `OEP_TLV_IF) ||
    (is_status(rx_frm.tlv0_type) &&
     rx_frm.tlv1_type == `OEP_TLV_IF);
  // A foreign TLV in front ends parsing
  assign end_tlv = rx_ccm && !is_status(rx_frm.tlv0_type) &&
    (rx_frm.tlv0_type != 8'h00);
  // Hardware processing is per type; disabled means no check or rewrite
  assign seq_hw = (rx_tst && ctrl_q[`OEP_C_TSTHW]) ||
    (rx_lbr && ctrl_q[`OEP_C_LBRHW]);
  assign mism = rx_frm.trans_id != (rx_trans_q + `OEP_ONE);
  assign seq_upd = (tx_tst && ctrl_q[`OEP_C_TSTHW] &&
    ctrl_q[`OEP_C_TSTSEQ]) || (tx_lbm && ctrl_q[`OEP_C_LBMHW] &&
    ctrl_q[`OEP_C_LBMSEQ]);
  // Reply CRC is meaningless in MPLS-TP: an ID TLV always leads
  assign crc_chk = rx_frm.test_first &&
    (rx_frm.pattern == `OEP_PAT1 || rx_frm.pattern == `OEP_PAT3) &&
    ((rx_tst && ctrl_q[`OEP_C_TSTCRC]) ||
     (rx_lbr && ctrl_q[`OEP_C_LBRCRC] &&
      !ctrl_q[`OEP_C_MPLSTP]));
  // Counter enables per PDU type
  assign cnt_rx = (rx_tst && ctrl_q[`OEP_C_CNT_TST]) ||
    (rx_lbm && ctrl_q[`OEP_C_CNT_LBM]) ||
    (rx_lbr && ctrl_q[`OEP_C_CNT_LBR]);
  assign cnt_tx = (tx_tst && ctrl_q[`OEP_C_CNT_TST]) ||
    (tx_lbm && ctrl_q[`OEP_C_CNT_LBM]) ||
    (tx_lbr && ctrl_q[`OEP_C_CNT_LBR]);
  assign dat_rx = (rx_tst && ctrl_q[`OEP_C_DAT_TST]) ||
    (rx_lbm && ctrl_q[`OEP_C_DAT_LBM]) ||
    (rx_lbr && ctrl_q[`OEP_C_DAT_LBR]);
  assign dat_tx = (tx_tst && ctrl_q[`OEP_C_DAT_TST]) ||
    (tx_lbm && ctrl_q[`OEP_C_DAT_LBM]) ||
    (tx_lbr && ctrl_q[`OEP_C_DAT_LBR]);
  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= 32'h00000000;
      irq_ena_q <= 3'h0;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == `OEP_A_IRQ_ENA) irq_ena_q <= reg_wdata[2:0];
    end
  end
  // ------------------------------------------------------------
  // Sticky flags: hardware set beats software write-one clear
  // ------------------------------------------------------------
  always_comb begin
    sticky_set = 32'h00000000;
    sticky_set[`OEP_S_PORT] = rx_ccm && !end_tlv && port_ok &&
      rx_frm.port_state != port_q;
    sticky_set[`OEP_S_IF] = rx_ccm && !end_tlv && if_ok &&
      rx_frm.if_state != if_q;
    sticky_set[`OEP_S_LOSS] = (rx_ccm && defect_q) ||
      (!rx_ccm && !defect_q && miss_q == `OEP_MISS_MAX);
    sticky_set[`OEP_S_END] = end_tlv;
    sticky_set[`OEP_S_TSTRX] = rx_tst;
    sticky_set[`OEP_S_LBMRX] = rx_lbm;
    sticky_set[`OEP_S_LBRRX] = rx_lbr;
    sticky_set[`OEP_S_MISM] = seq_hw && mism;
  end
  // Clear first, then set, so no event is lost to a racing clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) sticky_q <= 32'h00000000;
    else sticky_q <= (sticky_q & ~(wr_sticky ? reg_wdata : 32'h0)) |
      sticky_set;
  end
  // One interrupt line from enabled status flags
  assign irq = |(sticky_q[2:0] & irq_ena_q);
  // ------------------------------------------------------------
  // Peer status capture
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port_q <= 8'h00;
      if_q <= 8'h00;
    end else if (rx_ccm && !end_tlv) begin
      if (port_ok) port_q <= rx_frm.port_state;
      if (if_ok) if_q <= rx_frm.if_state;
    end
  end
  // ------------------------------------------------------------
  // Continuity: miss counter and defect
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) miss_q <= 3'h0;
    else if (rx_ccm) miss_q <= 3'h0;
    else if (loss_tick && miss_q != `OEP_MISS_MAX)
      miss_q <= miss_q + 3'h1;
  end
  // Defect follows the count one cycle later; a CCM always wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) defect_q <= 1'b0;
    else if (rx_ccm) defect_q <= 1'b0;
    else if (miss_q == `OEP_MISS_MAX) defect_q <= 1'b1;
  end
  // ------------------------------------------------------------
  // LM insertion request and one-shot extract
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) lmnext_q <= 1'b0;
    else if (lm_tick || (wr_stat && reg_wdata[`OEP_ST_LMNEXT]))
      lmnext_q <= 1'b1;
    else if (tx_ccm) lmnext_q <= 1'b0;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) extract_q <= 1'b0;
    else if (wr_extr && reg_wdata[0]) extract_q <= 1'b1;
    else if (rx_seq) extract_q <= 1'b0;
  end
  // ------------------------------------------------------------
  // Transaction values (TST and loopback share them)
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) tx_trans_q <= 32'h00000000;
    else if (seq_upd) tx_trans_q <= tx_trans_q + `OEP_ONE;
    else if (reg_wr && reg_addr == `OEP_A_TX_TRANS) tx_trans_q <= reg_wdata;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) rx_trans_q <= 32'h00000000;
    else if (seq_hw) rx_trans_q <= rx_frm.trans_id;
    else if (reg_wr && reg_addr == `OEP_A_RX_TRANS) rx_trans_q <= reg_wdata;
  end
  // ------------------------------------------------------------
  // TEST TLV CRC, built over the data bytes ahead of the frame
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n || rx_vld) crc_q <= `OEP_CRC_INIT;
    else if (rx_byte_vld) crc_q <= crc_byte(crc_q, rx_byte);
  end
  // ------------------------------------------------------------
  // Statistics: kept even with hardware processing off, except the mismatch count
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_cnt_q <= '0;
      mism_cnt_q <= '0;
      txrep_cnt_q <= '0;
      crc_cnt_q <= '0;
    end else begin
      if (rx_seq) rx_cnt_q <= rx_cnt_q + 1'b1;
      if (seq_hw && mism) mism_cnt_q <= mism_cnt_q + 1'b1;
      if (tx_lbr) txrep_cnt_q <= txrep_cnt_q + 1'b1;
      if (crc_chk && ~crc_q != rx_frm.crc)
        crc_cnt_q <= crc_cnt_q + 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oam_tx_q <= 16'h0000;
      oam_rx_q <= 16'h0000;
      dat_tx_q <= 16'h0000;
      dat_rx_q <= 16'h0000;
    end else begin
      if (cnt_tx) oam_tx_q <= oam_tx_q + 16'h0001;
      if (cnt_rx) oam_rx_q <= oam_rx_q + 16'h0001;
      if (dat_tx) dat_tx_q <= dat_tx_q + 16'h0001;
      if (dat_rx) dat_rx_q <= dat_rx_q + 16'h0001;
    end
  end
  // ------------------------------------------------------------
  // Pipeline outputs, one cycle after the frame
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_out_vld <= 1'b0;
      tx_out <= '0;
      lbr_inject <= 1'b0;
      cpu_copy <= 1'b0;
    end else begin
      tx_out_vld <= tx_vld;
      tx_out <= tx_frm;
      if (seq_upd) tx_out.seq <= tx_trans_q;
      tx_out.lm_insert <= tx_ccm &&
        (lmnext_q || tx_frm.lm_insert);
      lbr_inject <= rx_lbm && ctrl_q[`OEP_C_LBMHW] &&
        ctrl_q[`OEP_C_AUTOREP];
      cpu_copy <= (rx_seq && extract_q) ||
        (rx_tst && ctrl_q[`OEP_C_CPY_TST]) ||
        (rx_lbm && ctrl_q[`OEP_C_CPY_LBM]) ||
        (rx_lbr && ctrl_q[`OEP_C_CPY_LBR]) ||
        (end_tlv && ctrl_q[`OEP_C_CPY_END]);
    end
  end
  // ------------------------------------------------------------
  // Register read, data valid only in the cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !reg_rd) reg_rdata <= 32'h00000000;
    else begin
      unique case (reg_addr)
        `OEP_A_CTRL: reg_rdata <= ctrl_q;
        `OEP_A_IRQ_ENA: reg_rdata <= {29'h0, irq_ena_q};
        `OEP_A_STICKY: reg_rdata <= sticky_q;
        `OEP_A_CCM_STAT: reg_rdata <= {8'h00, if_q, port_q, 3'h0, lmnext_q,
                                      defect_q, miss_q};
        `OEP_A_TX_TRANS: reg_rdata <= tx_trans_q;
        `OEP_A_RX_TRANS: reg_rdata <= rx_trans_q;
        `OEP_A_RX_CNT: reg_rdata <= 32'(rx_cnt_q);
        `OEP_A_MISM_CNT: reg_rdata <= 32'(mism_cnt_q);
        `OEP_A_TXREP_CNT: reg_rdata <= 32'(txrep_cnt_q);
        `OEP_A_CRC_CNT: reg_rdata <= 32'(crc_cnt_q);
        `OEP_A_OAM_CNT: reg_rdata <= {oam_rx_q, oam_tx_q};
        `OEP_A_DATA_CNT: reg_rdata <= {dat_rx_q, dat_tx_q};
        `OEP_A_EXTRACT: reg_rdata <= {31'h0, extract_q};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_miss_clear: assert property (rx_ccm |=> miss_q == 3'h0)
    else $error("miss counter not cleared by CCM");
  a_miss_count: assert property (loss_tick && !rx_ccm && miss_q != 3'h7
    |=> miss_q == $past(miss_q) + 3'h1)
    else $error("miss counter did not count expiry");
  a_miss_sat: assert property (miss_q == 3'h7 && !rx_ccm
    |=> miss_q == 3'h7 && defect_q)
    else $error("miss counter wrapped or defect missing");
  a_defect_set: assert property (miss_q == 3'h6 && loss_tick && !rx_ccm
    ##1 !rx_ccm |=> defect_q)
    else $error("defect not set after seven expiries");
  a_loss_flag: assert property ($changed(defect_q)
    |-> sticky_q[`OEP_S_LOSS])
    else $error("defect change without loss flag");
  a_defect_clear: assert property (rx_ccm && defect_q
    |=> !defect_q && sticky_q[`OEP_S_LOSS])
    else $error("CCM did not clear defect");
  a_lm_insert: assert property (tx_ccm && lmnext_q && !lm_tick && !wr_stat
    |=> tx_out.lm_insert && !lmnext_q)
    else $error("LM insertion or clear missing");
  a_seq_write: assert property (seq_upd |=> tx_out.seq == $past(tx_trans_q)
    && tx_trans_q == $past(tx_trans_q) + 32'h1)
    else $error("sequence not written or not incremented");
  a_mism_count: assert property (seq_hw && mism
    |=> mism_cnt_q == $past(mism_cnt_q) + 1'b1
    && sticky_q[`OEP_S_MISM])
    else $error("transaction mismatch not recorded");
  a_lbr_valid: assert property (rx_lbr
    |=> rx_cnt_q == $past(rx_cnt_q) + 1'b1)
    else $error("received reply not counted");
  a_loop_reply: assert property (rx_lbm && ctrl_q[`OEP_C_LBMHW]
    && ctrl_q[`OEP_C_AUTOREP] |=> lbr_inject)
    else $error("loop reply not injected");
  a_tx_reply: assert property (tx_lbr
    |=> txrep_cnt_q == $past(txrep_cnt_q) + 1'b1)
    else $error("transmitted reply not counted");
  c_defect: cover property (!defect_q ##1 defect_q);
  c_crc_fail: cover property (crc_chk && ~crc_q != rx_frm.crc);
  c_loop: cover property (rx_lbm ##1 lbr_inject);
  c_lm: cover property (lm_tick ##[1:20] tx_out.lm_insert);
endmodule
`default_nettype wire

/* oep_pipe_model.sv */
// Frame pipeline model at the far side of the OAM endpoint.
// Assumes the bench calls its tasks; same clock as the endpoint.
`timescale 1ns/1ps
`default_nettype none
module oep_pipe_model import oep_pkg::*; (
  input wire logic ref_clk,
  input wire logic lbr_inject,
  output logic rx_byte_vld,
  output logic [7:0] rx_byte,
  output logic rx_vld,
  output oep_rx_s rx_frm,
  output logic tx_vld,
  output oep_tx_s tx_frm
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    rx_byte_vld = 1'b0;
    rx_byte = 8'h00;
    rx_vld = 1'b0;
    rx_frm = '0;
    tx_vld = 1'b0;
    tx_frm = '0;
  end
  // Sender drives TEST TLV bytes, first byte d[7:0]; the CRC comes in with the frame
  task automatic send_rx(input oep_rx_s f, input logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      rx_byte_vld <= 1'b1;
      rx_byte <= d[8*i +: 8];
    end
    @(posedge ref_clk);
    rx_byte_vld <= 1'b0;
    rx_byte <= ~d[31:24];
    rx_vld <= 1'b1;
    rx_frm <= f;
    @(posedge ref_clk);
    rx_vld <= 1'b0;
    rx_frm <= ~f; // Stale fields must not look valid
  endtask
  // One frame through the transmit lookup
  task automatic send_tx(input oep_tx_s f);
    @(posedge ref_clk);
    tx_vld <= 1'b1;
    tx_frm <= f;
    @(posedge ref_clk);
    tx_vld <= 1'b0;
    tx_frm <= ~f;
  endtask
  // Injected reply goes back through the transmit lookup
  always @(posedge ref_clk) begin
    if (lbr_inject === 1'b1) begin
      send_tx('{OEP_LBR, 32'h0, 1'b0});
    end
  end
endmodule
`default_nettype wire

/* test_oam_endpoint_ccm_test_loopback.sv */
// Self-checking bench for the OAM endpoint.
// Assumes the pipeline model and the register header beside it.
`include "oep_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_oam_endpoint_ccm_test_loopback;
  import oep_pkg::*;
  localparam logic [31:0] DAT = 32'h04030201;
  localparam logic [31:0] LB = 32'h000480B6;
  logic ref_clk, rst_n, reg_wr, reg_rd, rx_byte_vld, rx_vld, tx_vld;
  logic tx_out_vld, lbr_inject, cpu_copy, irq;
  logic [7:0] reg_addr, rx_byte, tmr_expire, pat;
  logic [31:0] reg_wdata, reg_rdata;
  oep_rx_s rx_frm;
  oep_tx_s tx_frm, tx_out;
  int mismatches = 0;
  int n_tests = 0;
  int n;
  oep_endpoint u_oep_endpoint (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tmr_expire(tmr_expire),
    .rx_byte_vld(rx_byte_vld), .rx_byte(rx_byte), .rx_vld(rx_vld),
    .rx_frm(rx_frm), .tx_vld(tx_vld), .tx_frm(tx_frm),
    .tx_out_vld(tx_out_vld), .tx_out(tx_out), .lbr_inject(lbr_inject),
    .cpu_copy(cpu_copy), .irq(irq));
  oep_pipe_model u_oep_pipe_model (.ref_clk(ref_clk),
    .lbr_inject(lbr_inject), .rx_byte_vld(rx_byte_vld), .rx_byte(rx_byte),
    .rx_vld(rx_vld), .rx_frm(rx_frm), .tx_vld(tx_vld), .tx_frm(tx_frm));
  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [39:0] e,
    input logic [39:0] v);
    n_tests++;
    if (v !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rchk(input string s, input logic [7:0] a,
    input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(s, {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic tick(input int b);
    @(posedge ref_clk);
    tmr_expire <= 8'h01 << b;
    @(posedge ref_clk);
    tmr_expire <= 8'h00;
  endtask
  task automatic tx(input oep_pdu_e k, input string s, input logic [32:0] e);
    u_oep_pipe_model.send_tx('{k, 32'h0, 1'b0});
    #1 chk(s, {7'h01, e}, {tx_out_vld, tx_out.seq, tx_out.lm_insert});
  endtask
  // Reflected CRC-32, data bit 0 first; independent of the design
  function automatic logic [31:0] crc32(input logic [31:0] d);
    logic [31:0] c;
    c = `OEP_CRC_INIT;
    for (int i = 0; i < 32; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ `OEP_CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction
  function automatic oep_rx_s mk(input oep_pdu_e k, input logic [31:0] t,
    input logic [7:0] t0, input logic [7:0] ps, input logic [7:0] pt,
    input logic [31:0] c);
    mk = '0;
    mk.kind = k;
    mk.trans_id = t;
    mk.tlv0_type = t0;
    mk.tlv1_type = `OEP_TLV_PORT;
    mk.port_state = ps;
    mk.pattern = pt;
    mk.test_first = 1'b1;
    mk.crc = c;
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    tmr_expire = 8'h00;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rchk("sticky", `OEP_A_STICKY, 32'h0);
    rchk("unmapped", 8'hFC, 32'h0);
    wr(`OEP_A_IRQ_ENA, 32'h4);
    wr(`OEP_A_CTRL, 32'h00401009);
    for (int i = 0; i < 6; i++) tick(0);
    rchk("miss6", `OEP_A_CCM_STAT, 32'h6);
    chk("irq_quiet", 0, irq);
    repeat (3) tick(0);
    rchk("loss", `OEP_A_CCM_STAT, 32'hF);
    chk("irq", 1, irq);
    wr(`OEP_A_IRQ_ENA, 32'h0);
    #1 chk("irq_mask", 0, irq);
    wr(`OEP_A_STICKY, 32'hFF);
    u_oep_pipe_model.send_rx(mk(OEP_CCM, 0, `OEP_TLV_IF, 8'h05, 0, 0), DAT);
    rchk("ccm_ok", `OEP_A_CCM_STAT, 32'h500);
    rchk("flags", `OEP_A_STICKY, 32'h5);
    u_oep_pipe_model.send_rx(mk(OEP_CCM, 0, 8'h07, 8'h09, 0, 0), DAT);
    #1 chk("end_copy", 1, cpu_copy);
    rchk("end_stat", `OEP_A_CCM_STAT, 32'h500);
    rchk("end_flag", `OEP_A_STICKY, 32'hD);
    $display("test continuity done");
    wr(`OEP_A_CCM_STAT, 32'h10);
    tx(OEP_CCM, "lm_sw", {32'h0, 1'b1});
    tx(OEP_CCM, "lm_clr", {32'h0, 1'b0});
    tick(1);
    tx(OEP_CCM, "lm_tmr", {32'h0, 1'b1});
    wr(`OEP_A_TX_TRANS, 32'h10);
    tx(OEP_TST, "tst_seq", {32'h10, 1'b0});
    tx(OEP_TST, "tst_seq2", {32'h11, 1'b0});
    wr(`OEP_A_CTRL, LB);
    tx(OEP_LBM, "lbm_seq", {32'h12, 1'b0});
    $display("test transmit done");
    wr(`OEP_A_STICKY, 32'hFF);
    wr(`OEP_A_EXTRACT, 32'h1);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wr(`OEP_A_CTRL, LB | 32'h100);
      pat = (i == 1) ? `OEP_PAT3 : (i == 3) ? 8'h02 : `OEP_PAT1;
      u_oep_pipe_model.send_rx(mk(OEP_LBR, (i == 0) ? 1 : i + 4, 8'h00, 0,
        pat, crc32(DAT) ^ ((i > 0) ? 32'h1 : 32'h0)), DAT);
      #1 chk("extract", (i == 0), cpu_copy);
    end
    rchk("crc_fail", `OEP_A_CRC_CNT, 32'h2);
    rchk("rx_cnt", `OEP_A_RX_CNT, 32'h5);
    rchk("mism_cnt", `OEP_A_MISM_CNT, 32'h1);
    rchk("rx_trans", `OEP_A_RX_TRANS, 32'h8);
    rchk("rx_flags", `OEP_A_STICKY, 32'hC0);
    rchk("oam_cnt", `OEP_A_OAM_CNT, 32'h00050000);
    rchk("dat_cnt", `OEP_A_DATA_CNT, 32'h00050000);
    u_oep_pipe_model.send_rx(mk(OEP_LBM, 0, 8'h00, 0, 0, 0), DAT);
    #1 chk("inject", 1, lbr_inject);
    n = 0;
    while (tx_out_vld !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("reply", 1, tx_out_vld);
    if (n == 10) complete_run();
    rchk("txrep", `OEP_A_TXREP_CNT, 32'h1);
    $display("test loopback done");
    complete_run();
  end
  // Cuts a hang short
  initial begin
    #4000000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
